//--- pkg/ddc_nco_pkg.sv
package ddc_nco_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] CTL1_IDX = 10'h080;
    localparam logic [9:0] CTL2_IDX = 10'h081;
    localparam logic [9:0] TUNE0_IDX = 10'h082;
    localparam logic [9:0] TUNE1_IDX = 10'h083;
    localparam logic [9:0] TUNE2_IDX = 10'h084;
    localparam logic [9:0] TUNE3_IDX = 10'h085;

    // First control register fields
    localparam int CTL1_HB_B_BIT = 7;
    localparam int CTL1_HB_A_BIT = 6;
    localparam int CTL1_OSC_BIT = 5;
    localparam int CTL1_ADITH_BIT = 4;
    localparam int CTL1_PDITH_BIT = 3;
    localparam int CTL1_PRNG_BIT = 2;
    localparam int CTL1_FS8_BIT = 1;
    localparam int CTL1_FIRST_DOWNCONV_STAGE_BIT = 0;

    // Second control register fields
    localparam int CTL2_BAND_BIT = 7;
    localparam int CTL2_SECOND_DOWNCONV_STAGE_BIT = 6;
    localparam int CTL2_HBGAIN_BIT = 5;
    localparam int CTL2_FDRSEL_BIT = 4;
    localparam int CTL2_DSPP8_BIT = 3;
    localparam int CTL2_CW_BIT = 2;
    localparam int CTL2_CWGAIN_LSB = 0;

    // Values after reset
    localparam logic [7:0] CTL1_RST = 8'h00;
    localparam logic [7:0] CTL2_RST = 8'h00;
    localparam logic [31:0] TUNE_RST = 32'h0000_0000;
    localparam logic [31:0] ACC_RST = 32'h0000_0000;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;

    // Cosine table in 45 degree steps, scale 127
    localparam int TRIG_SHIFT = 7;
    localparam int HB_SHIFT = 2;

    function automatic logic signed [7:0] cos_lut(input logic [2:0] k);
        case (k)
            3'h0: cos_lut = 8'sh7F;
            3'h1: cos_lut = 8'sh5A;
            3'h2: cos_lut = 8'sh00;
            3'h3: cos_lut = 8'shA6;
            3'h4: cos_lut = 8'sh81;
            3'h5: cos_lut = 8'shA6;
            3'h6: cos_lut = 8'sh00;
            default: cos_lut = 8'sh5A;
        endcase
    endfunction

    // Sine is cosine delayed by a quarter turn
    function automatic logic signed [7:0] sin_lut(input logic [2:0] k);
        sin_lut = cos_lut(3'(k + 3'h6));
    endfunction

endpackage

//--- design/ddc_nco_control.sv
`timescale 1ns/1ns
`default_nettype none

module ddc_nco_control
    import ddc_nco_pkg::*;
#(
    parameter int SW = 12,
    parameter int AW = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Samples from the conversion core
    input wire logic sample_valid_i,
    input wire logic signed [SW-1:0] sample_i,
    input wire logic sample_chan_b_i,
    input wire logic [2:0] sample_chan_idx_i,
    input wire logic dual_channel_i,
    // Stream toward the output formatter
    output logic out_valid_o,
    output logic signed [SW-1:0] out_i_o,
    output logic signed [SW-1:0] out_q_o,
    output logic out_chan_b_o,
    // Continuous-wave sum
    output logic cw_valid_o,
    output logic signed [SW+4:0] cw_data_o,
    // Settings for neighbouring blocks
    output logic delay_recovery_band_select_o,
    output logic delay_recovery_mode_select_o,
    output logic octal_postproc_enable_o
);

    localparam logic signed [31:0] SAT_MAX = 32'((1 <<< (SW - 1)) - 1);
    localparam logic signed [31:0] SAT_MIN = -SAT_MAX - 32'sh0000_0001;

    function automatic logic signed [SW-1:0] sat(
        input logic signed [31:0] v
    );
        if (v > SAT_MAX) begin
            sat = SAT_MAX[SW-1:0];
        end else if (v < SAT_MIN) begin
            sat = SAT_MIN[SW-1:0];
        end else begin
            sat = v[SW-1:0];
        end
    endfunction

    logic [7:0] ctl1_q;
    logic [7:0] ctl2_q;
    logic [31:0] tune_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_d;
    logic err_d;
    logic [9:0] idx;

    assign idx = paddr_i[AW-1:2];

    // Unaligned or unmapped addresses answer with an error, read zero
    always_comb begin
        rd_d = 32'h0000_0000;
        err_d = 1'b0;
        if (paddr_i[1:0] != 2'b00) begin
            err_d = 1'b1;
        end else begin
            case (idx)
                CTL1_IDX: rd_d = {24'h00_0000, ctl1_q};
                CTL2_IDX: rd_d = {24'h00_0000, ctl2_q};
                TUNE0_IDX: rd_d = {24'h00_0000, tune_q[7:0]};
                TUNE1_IDX: rd_d = {24'h00_0000, tune_q[15:8]};
                TUNE2_IDX: rd_d = {24'h00_0000, tune_q[23:16]};
                TUNE3_IDX: rd_d = {24'h00_0000, tune_q[31:24]};
                default: err_d = 1'b1;
            endcase
        end
    end

    // One wait state; answer is registered on the same edge that raises pready
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (psel_i && penable_i && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= err_d;
            prdata_q <= pwrite_i ? 32'h0000_0000 : rd_d;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    logic wr_en;

    // Write lands on the edge where pready is seen high
    assign wr_en = psel_i && penable_i && pready_q && pwrite_i &&
                   pstrb_i[0] && !err_d;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctl1_q <= CTL1_RST;
            ctl2_q <= CTL2_RST;
            tune_q <= TUNE_RST;
        end else if (wr_en) begin
            case (idx)
                CTL1_IDX: ctl1_q <= pwdata_i[7:0];
                CTL2_IDX: ctl2_q <= pwdata_i[7:0];
                TUNE0_IDX: tune_q[7:0] <= pwdata_i[7:0];
                TUNE1_IDX: tune_q[15:8] <= pwdata_i[7:0];
                TUNE2_IDX: tune_q[23:16] <= pwdata_i[7:0];
                TUNE3_IDX: tune_q[31:24] <= pwdata_i[7:0];
                default: ;
            endcase
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign delay_recovery_band_select_o = ctl2_q[CTL2_BAND_BIT];
    assign delay_recovery_mode_select_o = ctl2_q[CTL2_FDRSEL_BIT];
    assign octal_postproc_enable_o = ctl2_q[CTL2_DSPP8_BIT];

    logic first_downconv_stage_on;
    logic osc_on;
    logic prng_on;
    logic adith_on;
    logic pdith_on;
    logic rot_on;
    logic cw_on;

    assign first_downconv_stage_on = ctl1_q[CTL1_FIRST_DOWNCONV_STAGE_BIT];
    assign osc_on = first_downconv_stage_on && ctl1_q[CTL1_OSC_BIT];
    assign prng_on = ctl1_q[CTL1_PRNG_BIT];
    // Dither without the shift register is silently inert
    assign adith_on = ctl1_q[CTL1_ADITH_BIT] && prng_on;
    assign pdith_on = ctl1_q[CTL1_PDITH_BIT] && prng_on;
    assign rot_on = ctl2_q[CTL2_SECOND_DOWNCONV_STAGE_BIT] && ctl1_q[CTL1_FS8_BIT];
    assign cw_on = ctl2_q[CTL2_DSPP8_BIT] && ctl2_q[CTL2_CW_BIT];

    logic [31:0] acc_q;
    logic [15:0] lfsr_q;

    // Accumulator parks at zero while off so a restart is phase aligned
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            acc_q <= ACC_RST;
        end else if (osc_on) begin
            acc_q <= acc_q + tune_q;
        end else begin
            acc_q <= ACC_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            lfsr_q <= LFSR_SEED;
        end else if (prng_on) begin
            lfsr_q <= {lfsr_q[14:0],
                       lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        end
    end

    logic [31:0] ph_sum;
    logic [2:0] ph_idx;
    logic signed [31:0] xs;
    logic signed [31:0] adith_v;
    logic signed [31:0] nco_c;
    logic signed [31:0] nco_s;
    logic signed [31:0] mix_i;
    logic signed [31:0] mix_q;

    // Coarse eight-point table trades spur level for area
    assign ph_sum = acc_q + (pdith_on ? {16'h0000, lfsr_q} : 32'h0000_0000);
    assign ph_idx = ph_sum[31:29];
    assign xs = 32'(sample_i);
    assign adith_v = adith_on ? signed'({31'h0000_0000, lfsr_q[0]}) :
                     32'sh0000_0000;
    assign nco_c = 32'(cos_lut(ph_idx));
    assign nco_s = 32'(sin_lut(ph_idx));
    assign mix_i = osc_on ? ((xs * nco_c) >>> TRIG_SHIFT) + adith_v : xs;
    assign mix_q = osc_on ? -((xs * nco_s) >>> TRIG_SHIFT) + adith_v :
                   32'sh0000_0000;

    logic m_valid_q;
    logic m_b_q;
    logic signed [SW-1:0] m_i_q;
    logic signed [SW-1:0] m_q_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            m_valid_q <= 1'b0;
            m_b_q <= 1'b0;
            m_i_q <= '0;
            m_q_q <= '0;
        end else begin
            m_valid_q <= sample_valid_i && first_downconv_stage_on;
            // Single-channel traffic always lands on channel A
            m_b_q <= dual_channel_i && sample_chan_b_i;
            m_i_q <= sat(mix_i);
            m_q_q <= sat(mix_q);
        end
    end

    logic signed [31:0] hb_i [2];
    logic signed [31:0] hb_q [2];
    logic ph_q [2];

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_hb
            logic signed [31:0] h1i_q;
            logic signed [31:0] h2i_q;
            logic signed [31:0] h1q_q;
            logic signed [31:0] h2q_q;
            logic hp_sel;
            logic signed [31:0] xi;
            logic signed [31:0] xq;

            assign hp_sel = (c == 1) ? ctl1_q[CTL1_HB_B_BIT] :
                            ctl1_q[CTL1_HB_A_BIT];
            assign xi = 32'(m_i_q);
            assign xq = 32'(m_q_q);
            // Low pass 1 2 1, high pass -1 2 -1
            assign hb_i[c] = hp_sel ?
                ((-xi + (h1i_q <<< 1) - h2i_q) >>> HB_SHIFT) :
                ((xi + (h1i_q <<< 1) + h2i_q) >>> HB_SHIFT);
            assign hb_q[c] = hp_sel ?
                ((-xq + (h1q_q <<< 1) - h2q_q) >>> HB_SHIFT) :
                ((xq + (h1q_q <<< 1) + h2q_q) >>> HB_SHIFT);

            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    h1i_q <= 32'sh0000_0000;
                    h2i_q <= 32'sh0000_0000;
                    h1q_q <= 32'sh0000_0000;
                    h2q_q <= 32'sh0000_0000;
                    ph_q[c] <= 1'b0;
                end else if (m_valid_q && (m_b_q == (c == 1))) begin
                    h1i_q <= xi;
                    h2i_q <= h1i_q;
                    h1q_q <= xq;
                    h2q_q <= h1q_q;
                    ph_q[c] <= !ph_q[c];
                end
            end
        end
    endgenerate

    logic hb_fire;
    logic signed [31:0] hb_sel_i;
    logic signed [31:0] hb_sel_q;
    logic h_valid_q;
    logic h_b_q;
    logic signed [SW-1:0] h_i_q;
    logic signed [SW-1:0] h_q_q;

    // Only every second sample of a channel leaves the filter
    assign hb_fire = m_valid_q && (m_b_q ? ph_q[1] : ph_q[0]);
    assign hb_sel_i = m_b_q ? hb_i[1] : hb_i[0];
    assign hb_sel_q = m_b_q ? hb_q[1] : hb_q[0];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            h_valid_q <= 1'b0;
            h_b_q <= 1'b0;
            h_i_q <= '0;
            h_q_q <= '0;
        end else begin
            h_valid_q <= hb_fire;
            h_b_q <= m_b_q;
            if (ctl2_q[CTL2_HBGAIN_BIT]) begin
                h_i_q <= sat(hb_sel_i <<< 1);
                h_q_q <= sat(hb_sel_q <<< 1);
            end else begin
                h_i_q <= sat(hb_sel_i);
                h_q_q <= sat(hb_sel_q);
            end
        end
    end

    logic [2:0] rot_k_q;
    logic signed [31:0] hi32;
    logic signed [31:0] hq32;
    logic signed [31:0] rc;
    logic signed [31:0] rs;
    logic signed [31:0] rot_i;
    logic signed [31:0] rot_q;

    // Eighth-rate rotation after the filter, one step per output sample
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rot_k_q <= 3'h0;
        end else if (!rot_on) begin
            rot_k_q <= 3'h0;
        end else if (h_valid_q) begin
            rot_k_q <= rot_k_q + 3'h1;
        end
    end

    assign hi32 = 32'(h_i_q);
    assign hq32 = 32'(h_q_q);
    assign rc = 32'(cos_lut(rot_k_q));
    assign rs = 32'(sin_lut(rot_k_q));
    assign rot_i = rot_on ? ((hi32 * rc - hq32 * rs) >>> TRIG_SHIFT) : hi32;
    assign rot_q = rot_on ? ((hi32 * rs + hq32 * rc) >>> TRIG_SHIFT) : hq32;

    logic out_valid_q;
    logic out_b_q;
    logic signed [SW-1:0] out_i_q;
    logic signed [SW-1:0] out_q_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            out_valid_q <= 1'b0;
            out_b_q <= 1'b0;
            out_i_q <= '0;
            out_q_q <= '0;
        end else if (first_downconv_stage_on) begin
            out_valid_q <= h_valid_q;
            out_b_q <= h_b_q;
            out_i_q <= sat(rot_i);
            out_q_q <= sat(rot_q);
        end else begin
            // Bypass: raw samples, quadrature held at zero
            out_valid_q <= sample_valid_i;
            out_b_q <= dual_channel_i && sample_chan_b_i;
            out_i_q <= sample_i;
            out_q_q <= '0;
        end
    end

    assign out_valid_o = out_valid_q;
    assign out_i_o = out_i_q;
    assign out_q_o = out_q_q;
    assign out_chan_b_o = out_b_q;

    logic signed [SW+2:0] cw_acc_q;
    logic signed [SW+2:0] cw_sum;
    logic cw_valid_q;
    logic signed [SW+4:0] cw_data_q;

    // Channel samples arrive already phase, gain and offset adjusted
    assign cw_sum = (sample_chan_idx_i == 3'h0) ? (SW+3)'(sample_i) :
                    cw_acc_q + (SW+3)'(sample_i);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cw_acc_q <= '0;
            cw_valid_q <= 1'b0;
            cw_data_q <= '0;
        end else begin
            cw_valid_q <= 1'b0;
            if (cw_on && sample_valid_i) begin
                cw_acc_q <= cw_sum;
                if (sample_chan_idx_i == 3'h7) begin
                    cw_valid_q <= 1'b1;
                    case (ctl2_q[CTL2_CWGAIN_LSB +: 2])
                        2'b00: cw_data_q <= (SW+5)'(cw_sum);
                        2'b01: cw_data_q <= (SW+5)'(cw_sum) <<< 1;
                        default: cw_data_q <= (SW+5)'(cw_sum) <<< 2;
                    endcase
                end
            end
        end
    end

    assign cw_valid_o = cw_valid_q;
    assign cw_data_o = cw_data_q;

endmodule

`default_nettype wire

//--- verif/ddc_nco_control_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ddc_nco_control_checker #(
    parameter int AW = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Register bus
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Stream and exported settings
    input wire logic sample_valid_i,
    input wire logic [2:0] sample_chan_idx_i,
    input wire logic cw_valid_o,
    input wire logic delay_recovery_band_select_o,
    input wire logic delay_recovery_mode_select_o,
    input wire logic octal_postproc_enable_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    logic ctl2_wr;
    assign ctl2_wr = psel_i && penable_i && pready_o && pwrite_i &&
        paddr_i == AW'(12'h204) && pstrb_i[0];
    a_ready_once: assert property (pready_o |=> !pready_o)
        else $error("ready held past one cycle");
    a_ready_answer: assert property (
        psel_i && penable_i && !pready_o |=> pready_o)
        else $error("access phase not answered");
    a_ready_unasked: assert property (!$past(psel_i) |-> !pready_o)
        else $error("ready without a select");
    a_err_qualified: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_read_byte_only: assert property (
        pready_o && !pwrite_i |-> prdata_o[31:8] == '0)
        else $error("read data above the byte not zero");
    a_band_write: assert property (
        ctl2_wr |=> delay_recovery_band_select_o == $past(pwdata_i[7]))
        else $error("band select not taken from write");
    a_mode_write: assert property (
        ctl2_wr |=> delay_recovery_mode_select_o == $past(pwdata_i[4]))
        else $error("mode select not taken from write");
    a_octal_write: assert property (
        ctl2_wr |=> octal_postproc_enable_o == $past(pwdata_i[3]))
        else $error("octal enable not taken from write");
    a_cw_gated: assert property (
        !$past(octal_postproc_enable_o) |-> !cw_valid_o)
        else $error("sum emitted while octal features off");
    a_cw_cause: assert property (
        cw_valid_o |-> $past(sample_valid_i && sample_chan_idx_i == 3'h7))
        else $error("sum emitted without a last channel sample");
    c_ctl2_write: cover property (ctl2_wr);
    c_cw_sum: cover property (cw_valid_o);
    c_refused: cover property (pslverr_o);
endmodule
bind ddc_nco_control ddc_nco_control_checker #(.AW(AW)) chk_i (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sample_valid_i(sample_valid_i),
    .sample_chan_idx_i(sample_chan_idx_i), .cw_valid_o(cw_valid_o),
    .delay_recovery_band_select_o(delay_recovery_band_select_o),
    .delay_recovery_mode_select_o(delay_recovery_mode_select_o),
    .octal_postproc_enable_o(octal_postproc_enable_o));
`default_nettype wire

//--- verif/sample_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module sample_core_model #(
    parameter int SW = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Burst request from the bench
    input wire logic start_i,
    input wire logic [4:0] count_i,
    input wire logic ramp_i,
    input wire logic dual_i,
    input wire logic signed [SW-1:0] level_i,
    // Samples toward the block
    output logic sample_valid_o,
    output logic signed [SW-1:0] sample_o,
    output logic chan_b_o,
    output logic [2:0] chan_idx_o
);
    logic [4:0] left_q;
    logic [4:0] pos_q;
    always_ff @(posedge clk_i) begin
        if (reset_i || start_i) begin
            left_q <= reset_i ? 5'h0 : count_i;
            pos_q <= 5'h0;
            sample_valid_o <= 1'b0;
            sample_o <= '0;
        end else if (left_q != 5'h0) begin
            left_q <= left_q - 5'h1;
            pos_q <= pos_q + 5'h1;
            sample_valid_o <= 1'b1;
            sample_o <= ramp_i ? SW'(pos_q + 5'h1) : level_i;
        end else begin
            // Idle data toggles so a stale sample is never taken
            sample_valid_o <= 1'b0;
            sample_o <= ~sample_o;
        end
    end
    // Dual mode interleaves A and B; ramp index walks the octal set
    always_ff @(posedge clk_i) begin
        chan_b_o <= dual_i & pos_q[0];
        chan_idx_o <= pos_q[2:0];
    end
endmodule
`default_nettype wire

//--- verif/ddc_nco_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module ddc_nco_control_tb_top
    import ddc_nco_pkg::*;
;
    logic clk, rst, psel, penable, pwrite, start, ramp, dual;
    logic pready, pslverr, sv, chb, outv, ochb, cwv, band, mode, octal;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [2:0] idx;
    logic [4:0] cnt;
    logic signed [11:0] smp, level, oi, oq, last_a, last_b, last_q;
    logic signed [16:0] cwd, last_cw;
    int n_mismatch, comparisons, n_out, n_cw;
    localparam logic [9:0] IDX [6] = '{CTL1_IDX, CTL2_IDX, TUNE0_IDX,
        TUNE1_IDX, TUNE2_IDX, TUNE3_IDX};
    ddc_nco_control #(.SW(12), .AW(12)) ddc_nco_control_i (
        .clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .sample_valid_i(sv), .sample_i(smp),
        .sample_chan_b_i(chb), .sample_chan_idx_i(idx),
        .dual_channel_i(dual), .out_valid_o(outv), .out_i_o(oi),
        .out_q_o(oq), .out_chan_b_o(ochb), .cw_valid_o(cwv),
        .cw_data_o(cwd), .delay_recovery_band_select_o(band),
        .delay_recovery_mode_select_o(mode),
        .octal_postproc_enable_o(octal));
    sample_core_model #(.SW(12)) sample_core_model_i (
        .clk_i(clk), .reset_i(rst), .start_i(start), .count_i(cnt),
        .ramp_i(ramp), .dual_i(dual), .level_i(level),
        .sample_valid_o(sv), .sample_o(smp), .chan_b_o(chb),
        .chan_idx_o(idx));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (outv === 1'b1) begin
            n_out++;
            if (ochb) begin
                last_b = oi;
            end else begin
                last_a = oi;
                last_q = oq;
            end
        end
        if (cwv === 1'b1) begin
            n_cw++;
            last_cw = cwd;
        end
    end
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] wd, input logic [3:0] st,
        output logic [31:0] rd, output logic err);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input string what, input logic [11:0] a,
        input logic [31:0] exp, input logic eerr);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, '0, 4'h0, rd, err);
        check(what, rd, exp);
        check({what, " error"}, 32'(err), 32'(eerr));
    endtask
    task automatic wreg(input logic [11:0] a, input logic [7:0] v,
        input logic [3:0] st = 4'h1);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, {24'hFFFF_FF, v}, st, rd, err);
    endtask
    // Fixed wait of 40 edges: pipeline latency is three edges, one in bypass
    task automatic burst(input logic [4:0] n, input logic r,
        input logic signed [11:0] lv);
        cnt <= n;
        ramp <= r;
        level <= lv;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (40) @(posedge clk);
    endtask
    task automatic t_regs();
        for (int i = 0; i < 6; i++) begin
            rdchk("reset", {IDX[i], 2'b00}, '0, 1'b0);
            wreg({IDX[i], 2'b00}, 8'h3C + 8'(i));
            rdchk("stored", {IDX[i], 2'b00},
                32'(8'h3C + 8'(i)), 1'b0);
        end
        check("mode out", 32'(mode), 32'h1);
        check("octal out", 32'(octal), 32'h1);
        wreg({CTL2_IDX, 2'b00}, 8'hFF, 4'h0);
        rdchk("no strobe", {CTL2_IDX, 2'b00}, 32'h3D, 1'b0);
        rdchk("unmapped", 12'h218, '0, 1'b1);
        rdchk("unaligned", 12'h205, '0, 1'b1);
        wreg({CTL2_IDX, 2'b00}, 8'h80);
        check("band out", 32'(band), 32'h1);
        for (int i = 0; i < 6; i++) begin
            wreg({IDX[i], 2'b00}, 8'h00);
        end
    endtask
    task automatic t_bypass();
        int n0;
        wreg({TUNE3_IDX, 2'b00}, 8'h40);
        wreg({CTL1_IDX, 2'b00}, 8'h20);
        n0 = n_out;
        burst(5'h01, 1'b0, 12'h064);
        check("bypass count", 32'(n_out - n0), 32'h1);
        check("bypass data", 32'(last_a), 32'h64);
        check("bypass quad", 32'(last_q), '0);
    endtask
    task automatic t_decim(input logic [7:0] c2, input logic [31:0] e);
        int n0;
        // Zero tune word: oscillator sits at phase zero, gain 127/128
        wreg({TUNE3_IDX, 2'b00}, 8'h00);
        wreg({CTL2_IDX, 2'b00}, c2);
        wreg({CTL1_IDX, 2'b00}, 8'hA1);
        n0 = n_out;
        burst(5'h10, 1'b0, 12'h040);
        check("decimated count", 32'(n_out - n0), 32'h8);
        check("lowpass out", 32'(last_a), e);
        check("zero tune quad", 32'(last_q), '0);
    endtask
    task automatic t_dual();
        int n0;
        dual <= 1'b1;
        wreg({CTL2_IDX, 2'b00}, 8'h00);
        n0 = n_out;
        burst(5'h10, 1'b0, 12'h040);
        check("dual count", 32'(n_out - n0), 32'h8);
        check("dual lowpass", 32'(last_a), 32'h3F);
        check("dual highpass", 32'(last_b), '0);
        dual <= 1'b0;
    endtask
    task automatic t_cw();
        int n0;
        logic [7:0] c2;
        for (int g = 0; g < 6; g++) begin
            c2 = (g < 4) ? 8'h0C | 8'(g) : ((g == 4) ? 8'h04 : 8'h08);
            wreg({CTL2_IDX, 2'b00}, c2);
            n0 = n_cw;
            burst(5'h08, 1'b1, '0);
            check("cw count", 32'(n_cw - n0), 32'(g < 4));
            if (g < 4) begin
                check("cw sum", 32'(last_cw),
                    32'h24 << ((g > 2) ? 2 : g));
            end
        end
    endtask
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, start, ramp, dual} = '0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        cnt = '0;
        level = '0;
        {n_mismatch, comparisons, n_out, n_cw} = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_bypass();
        t_decim(8'h00, 32'h3F);
        t_decim(8'h20, 32'h7E);
        t_dual();
        t_cw();
        tally_and_finish();
    end
endmodule
`default_nettype wire
